//--- src/dac_ctrl_pkg.sv
// package: constants, field layout and types of the converter mode-control block
`default_nettype none
package dac_ctrl_pkg;
  // serial frame layout
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [4:0] LAST_BIT_IDX = 5'h17;
  localparam logic [4:0] FRAME_DONE_CNT = 5'h18;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int FIXED_ZERO_BIT = 20;
  localparam int SHORT_BIT = 12;
  localparam int UNDERVOLT_BIT = 11;
  localparam int CTRL_W = 11;
  // register address codes carried in bits 19:16
  localparam logic [3:0] CMD_UPDATE_DAC = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_WRITE_CTRL = 4'h4;
  localparam logic [3:0] CMD_READ_CTRL = 4'hC;
  localparam logic [3:0] CMD_FULL_RESET = 4'hF;
  // mode-control register address and value after reset
  localparam logic [3:0] DAC_MODE_CONTROL_ADDR = 4'h4;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  // synchroniser depth for pins
  localparam int SYNC_STAGES = 3;

  // mode-control fields, in their bit order 10:0
  typedef struct packed {
    logic [1:0] clear_code_sel;
    logic range_extend_en;
    logic signed_coding_sel;
    logic thermal_supply_cut;
    logic internal_vref_on;
    logic [1:0] powerup_code_sel;
    logic [2:0] output_span_sel;
  } ctrl_fields_t;

  // pins arriving from outside the clk domain
  typedef struct packed {
    logic frame_toggle;
    logic clear_n;
    logic short_det;
    logic undervolt_det;
    logic overtemp_det;
  } pin_bundle_t;

  // scale presets applied to the output
  typedef enum logic [1:0] {
    SCALE_ZERO = 2'h0,
    SCALE_MID = 2'h1,
    SCALE_FULL = 2'h2
  } scale_t;

  // output stage state, one-hot
  typedef enum logic [1:0] {
    ST_CLAMPED = 2'h1,
    ST_ACTIVE = 2'h2
  } out_state_t;
endpackage
`default_nettype wire

//--- src/pin_sync.sv
// three-stage synchroniser whose output moves once stages two and three agree
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // raw and cleaned levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1; // metastability catcher, read only by stage2
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree; // per-bit agreement of stages two and three

  assign agree = ~(stage2 ^ stage3);

  // shift chain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (ce) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a bit only when the last two stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync_out[i] <= 1'b0;
        end else if (ce && agree[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- src/dac_control_register.sv
// serial mode-control register of a voltage-output converter, with readback and flags
//
// Function
// [RULE_01] reset clamps output, buffer powered down
// [RULE_02] control write configures, unclamps, powers buffer
// [RULE_03] host full-resets before changing output span
// [RULE_04] control write: code 0100, bit20 zero
// [RULE_05] clear code selects zero, mid, full
// [RULE_06] overrange bit enables five percent extension
// [RULE_07] coding bit: straight binary or twos complement
// [RULE_08] twos complement maps by inverting MSB
// [RULE_09] overheat cuts digital supply only if set
// [RULE_10] reference bit turns internal reference on
// [RULE_11] power-up code selects zero, mid, full
// [RULE_12] range field selects one of eight spans
// [RULE_13] readback request code 1100, data ignored
// [RULE_14] next frame shifts control word out MSB-first
// [RULE_15] readback word: address, flags, fields
// [RULE_16] short flag sticky, cleared by control write
// [RULE_17] brownout flag sticky, cleared by control write
// [RULE_18] every command is 24 bits, MSB-first
// [RULE_19] alert low after reset, high after write
// [RULE_20] clear falling edge holds clear value; code ignores the edge while the output is clamped
// [RULE_21] configuring write applies power-up preset
// [RULE_22] all fields zero after any reset
`default_nettype none
module dac_control_register
  import dac_ctrl_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // system clock domain
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // serial link, on its own clock
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output logic serial_out,
  // asynchronous pins and analog monitors
  input wire logic clear_n,
  input wire logic short_det,
  input wire logic undervolt_det,
  input wire logic overtemp_det,
  // data path from the dac register logic
  input wire logic dac_load,
  input wire logic [DATA_W-1:0] dac_word_in,
  output logic [DATA_W-1:0] dac_word_out,
  // analog controls
  output logic out_clamp_en,
  output logic out_buf_pwr,
  output logic alert_n,
  output logic digital_supply_off,
  output logic internal_vref_on,
  output logic range_extend_en,
  output logic [2:0] output_span_sel,
  output logic preset_active,
  output logic [1:0] preset_scale
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // map a two-bit scale code onto the preset it selects
  function automatic scale_t scale_of(input logic [1:0] code);
    scale_t s;
    s = SCALE_FULL;
    if (code == 2'h0) begin
      s = SCALE_ZERO;
    end else if (code == 2'h1) begin
      s = SCALE_MID;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: frame capture and readback shift

  logic [CNT_W-1:0] bit_cnt; // bits taken in this frame
  logic [FRAME_BITS-2:0] in_shift; // bits taken so far
  logic [FRAME_BITS-1:0] frame_word; // last whole frame
  logic frame_toggle; // flips once per whole frame
  logic [FRAME_BITS-1:0] out_shift; // readback shifter
  logic [FRAME_BITS-1:0] out_src; // word loaded at frame start

  // bit counter, cleared while the frame strobe is high
  always_ff @(posedge sclk or negedge reset_n or posedge sync_n) begin
    if (!reset_n) begin
      bit_cnt <= '0;
    end else if (sync_n) begin
      bit_cnt <= '0;
    end else if (bit_cnt != FRAME_DONE_CNT) begin
      bit_cnt <= bit_cnt + 5'h01; // [RULE_18]
    end
  end

  // shift in, MSB first; bits past the 24th are dropped
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      in_shift <= '0;
    end else if (bit_cnt != FRAME_DONE_CNT) begin
      in_shift <= {in_shift[FRAME_BITS-3:0], sdi}; // [RULE_18]
    end
  end

  // whole frame latched on its 24th edge
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      frame_word <= '0;
      frame_toggle <= 1'b0;
    end else if (bit_cnt == LAST_BIT_IDX) begin
      frame_word <= {in_shift, sdi}; // [RULE_18]
      frame_toggle <= ~frame_toggle;
    end
  end

  // readback shifter: loads on the first edge, then shifts MSB first
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      out_shift <= '0;
    end else if (bit_cnt == '0) begin
      out_shift <= out_src; // [RULE_14]
    end else if (bit_cnt != FRAME_DONE_CNT) begin
      out_shift <= {out_shift[FRAME_BITS-2:0], 1'b0}; // [RULE_14]
    end
  end

  assign serial_out = out_shift[FRAME_BITS-1];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers into the clk domain

  pin_bundle_t raw_pins; // raw asynchronous levels
  pin_bundle_t pins; // cleaned levels
  pin_bundle_t pins_d; // one cycle older, for edges

  assign raw_pins = '{frame_toggle: frame_toggle, clear_n: clear_n, short_det: short_det,
                      undervolt_det: undervolt_det, overtemp_det: overtemp_det};

  pin_sync #(
    .WIDTH($bits(pin_bundle_t))
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .async_in(raw_pins),
    .sync_out(pins)
  );

  // delayed copy for edges; resets like the synchroniser, so no false clear edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pins_d <= '{frame_toggle: 1'b0, clear_n: 1'b0, short_det: 1'b0,
                  undervolt_det: 1'b0, overtemp_det: 1'b0};
    end else if (ce) begin
      pins_d <= pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode in the clk domain

  wire frame_seen = pins.frame_toggle ^ pins_d.frame_toggle; // whole frame arrived
  wire [3:0] frame_addr = frame_word[ADDR_MSB:ADDR_LSB];
  wire frame_legal = ~frame_word[FIXED_ZERO_BIT];
  wire cmd_write_ctrl = frame_seen && frame_legal && frame_addr == CMD_WRITE_CTRL; // [RULE_04]
  wire cmd_read_ctrl = frame_seen && frame_legal && frame_addr == CMD_READ_CTRL; // [RULE_13]
  wire cmd_full_reset = frame_seen && frame_legal && frame_addr == CMD_FULL_RESET;
  wire cmd_dac_load = frame_seen && frame_legal &&
                      (frame_addr == CMD_UPDATE_DAC || frame_addr == CMD_WRITE_UPDATE);
  wire clear_fall = pins_d.clear_n & ~pins.clear_n; // falling clear edge
  wire load_event = dac_load | cmd_dac_load; // new dac register load

  ////////////////////////////////////////////////////////////////////////////
  // mode-control register and sticky flags

  ctrl_fields_t ctrl; // stored fields
  ctrl_fields_t next_ctrl;
  logic short_flag; // sticky short circuit
  logic undervolt_flag; // sticky brownout
  logic next_short_flag;
  logic next_undervolt_flag;

  // fields: written by a control write, zeroed by full reset
  always_comb begin
    next_ctrl = ctrl;
    if (cmd_full_reset) begin
      next_ctrl = ctrl_fields_t'(CTRL_RESET); // [RULE_22]
    end else if (cmd_write_ctrl) begin
      next_ctrl = ctrl_fields_t'(frame_word[CTRL_W-1:0]); // [RULE_04]
    end
  end

  // flags: a detection in the clearing cycle wins over the clear
  always_comb begin
    next_short_flag = short_flag;
    next_undervolt_flag = undervolt_flag;
    if (cmd_full_reset || cmd_write_ctrl) begin
      next_short_flag = 1'b0; // [RULE_16]
      next_undervolt_flag = 1'b0; // [RULE_17]
    end
    if (pins.short_det) begin
      next_short_flag = 1'b1; // [RULE_16]
    end
    if (pins.undervolt_det) begin
      next_undervolt_flag = 1'b1; // [RULE_17]
    end
  end

  // register update
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= ctrl_fields_t'(CTRL_RESET); // [RULE_22]
      short_flag <= 1'b0;
      undervolt_flag <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      short_flag <= next_short_flag;
      undervolt_flag <= next_undervolt_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback word handed to the link domain

  logic read_armed; // next frame carries the readback
  logic [FRAME_BITS-1:0] read_word; // snapshot taken at the request
  wire [FRAME_BITS-1:0] live_word = {3'h0, 1'b0, CMD_READ_CTRL, 3'h0,
                                     short_flag, undervolt_flag, ctrl}; // [RULE_15]

  // snapshot settles here long before the host opens the next frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_armed <= 1'b0;
      read_word <= '0;
    end else if (ce && frame_seen) begin
      read_armed <= cmd_read_ctrl; // [RULE_14]
      read_word <= live_word; // [RULE_15]
    end
  end

  // quasi-static word, only sampled by the link at a frame start
  assign out_src = read_armed ? read_word : '0; // [RULE_14]

  ////////////////////////////////////////////////////////////////////////////
  // output stage state

  out_state_t out_state; // clamped until configured
  out_state_t next_out_state;

  // configure on a control write, back to clamped on full reset
  always_comb begin
    next_out_state = out_state;
    unique case (out_state)
      ST_CLAMPED: begin
        if (cmd_write_ctrl && !cmd_full_reset) begin
          next_out_state = ST_ACTIVE; // [RULE_02]
        end
      end
      ST_ACTIVE: begin
        if (cmd_full_reset) begin
          next_out_state = ST_CLAMPED; // [RULE_01]
        end
      end
      default: begin
        next_out_state = ST_CLAMPED;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_state <= ST_CLAMPED; // [RULE_01]
    end else if (ce) begin
      out_state <= next_out_state;
    end
  end

  wire configured = (out_state == ST_ACTIVE);

  assign out_clamp_en = ~configured; // [RULE_01]
  assign out_buf_pwr = configured; // [RULE_02]
  assign alert_n = configured & ~pins.overtemp_det; // [RULE_19]
  assign digital_supply_off = pins.overtemp_det & ctrl.thermal_supply_cut; // [RULE_09]
  assign internal_vref_on = ctrl.internal_vref_on; // [RULE_10]
  assign range_extend_en = ctrl.range_extend_en; // [RULE_06]
  assign output_span_sel = ctrl.output_span_sel; // [RULE_12]

  ////////////////////////////////////////////////////////////////////////////
  // preset values: power-up code and clear code

  logic preset_hold; // a preset overrides the dac word
  logic [1:0] preset_code; // preset in force

  // configuring write applies power-up preset; clear edge on a configured device applies clear preset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      preset_hold <= 1'b0;
      preset_code <= SCALE_ZERO;
    end else if (ce) begin
      if (cmd_full_reset) begin
        preset_hold <= 1'b0;
        preset_code <= SCALE_ZERO;
      end else if (clear_fall && configured) begin
        preset_hold <= 1'b1;
        preset_code <= scale_of(ctrl.clear_code_sel); // [RULE_05] [RULE_20]
      end else if (cmd_write_ctrl && !configured) begin
        preset_hold <= 1'b1;
        preset_code <= scale_of(next_ctrl.powerup_code_sel); // [RULE_11] [RULE_21]
      end else if (load_event) begin
        preset_hold <= 1'b0; // [RULE_20]
      end
    end
  end

  assign preset_active = preset_hold;
  assign preset_scale = preset_code;

  ////////////////////////////////////////////////////////////////////////////
  // input coding for bipolar spans

  // twos complement becomes straight binary by flipping the MSB
  wire [DATA_W-1:0] coded_word = ctrl.signed_coding_sel ?
    {~dac_word_in[DATA_W-1], dac_word_in[DATA_W-2:0]} : dac_word_in; // [RULE_07] [RULE_08]

  // converted word registered on each dac_load
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_word_out <= '0;
    end else if (ce && dac_load) begin
      dac_word_out <= coded_word; // [RULE_07]
    end
  end

endmodule
`default_nettype wire

//--- bench/dac_control_register_asserts.sv
// port-level checks of the converter mode-control register
`default_nettype none
module dac_control_register_asserts import dac_ctrl_pkg::*; #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // causes
  input wire logic dac_load,
  input wire logic [DATA_W-1:0] dac_word_in,
  input wire logic overtemp_det,
  // watched outputs
  input wire logic [DATA_W-1:0] dac_word_out,
  input wire logic out_clamp_en,
  input wire logic out_buf_pwr,
  input wire logic alert_n,
  input wire logic digital_supply_off,
  input wire logic [2:0] output_span_sel,
  input wire logic preset_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // clamp and buffer power are always opposite
  a_clamp_buf_pair: assert property (out_clamp_en != out_buf_pwr)
    else $error("clamp and buffer power agree");
  // state right after every reset release
  a_reset_state: assert property ($rose(reset_n) |-> out_clamp_en && !alert_n && !preset_active
    && output_span_sel == 3'h0)
    else $error("bad state after reset");
  // alert may only rise on a configured device
  a_alert_needs_write: assert property ($rose(alert_n) |-> ##[0:1] !out_clamp_en)
    else $error("alert high while clamped");
  // configuring write lifts alert
  a_alert_after_write: assert property ($fell(out_clamp_en) && !overtemp_det |-> ##[0:1] alert_n)
    else $error("alert stays low after write");
  // first write applies the power-up preset
  a_preset_at_release: assert property ($fell(out_clamp_en) |-> ##[0:2] preset_active)
    else $error("no preset on release");
  // a nonzero span only comes with a configuring write
  a_span_clamp: assert property (output_span_sel != 3'h0 |-> ##[0:3] !out_clamp_en)
    else $error("span set while clamped");
  // low bits of a loaded word pass unchanged
  a_load_word: assert property (dac_load && ce |=>
    dac_word_out[DATA_W-2:0] == $past(dac_word_in[DATA_W-2:0]))
    else $error("loaded word wrong");
  // supply cut comes only with an overheat alert
  a_supply_alert: assert property (digital_supply_off |-> !alert_n)
    else $error("supply cut without alert");
endmodule
bind dac_control_register dac_control_register_asserts #(.DATA_W(DATA_W)) u_chk (.clk, .reset_n, .ce, .dac_load,
  .dac_word_in, .overtemp_det, .dac_word_out, .out_clamp_en, .out_buf_pwr, .alert_n, .digital_supply_off,
  .output_span_sel, .preset_active);
`default_nettype wire

//--- bench/dac_host_model.sv
// host serial master: sends frames and collects the answer
`default_nettype none
module dac_host_model (
  // link driven by the host
  output var logic sclk,
  output var logic sync_n,
  output var logic sdi,
  input wire logic serial_out,
  // captured answer
  output var logic rx_valid,
  output var logic [23:0] rx_word
);
  timeunit 1ns;
  timeprecision 100ps;
  // link idle, clock stopped
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
    rx_valid = 1'b0;
    rx_word = 24'h000000;
  end
  // one frame, msb first, 6 ns clock only inside the frame
  task automatic xfer(input logic [23:0] tx, input logic keep);
    sync_n = 1'b0;
    for (int k = 23; k >= 0; k--) begin
      sdi = tx[k];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
      rx_word[k] = serial_out;
    end
    sync_n = 1'b1;
    sdi = ~sdi; // no stale bit left on the line
    rx_valid = keep;
    #40 rx_valid = 1'b0; // gap lets the readback snapshot settle
  endtask
endmodule
`default_nettype wire

//--- bench/dac_control_register_tb.sv
// self-checking bench of the converter mode-control register
`default_nettype none
module dac_control_register_tb import dac_ctrl_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // stimulus
  logic clk = 1'b0, reset_n, clear_n = 1'b1, short_det = 1'b0, undervolt_det = 1'b0;
  logic overtemp_det = 1'b0, dac_load = 1'b0;
  logic [15:0] dac_word_in = 16'h0000;
  // observed
  wire sclk, sync_n, sdi, serial_out, rx_valid, out_clamp_en, out_buf_pwr, alert_n, digital_supply_off;
  wire internal_vref_on, range_extend_en, preset_active;
  wire [23:0] rx_word;
  wire [15:0] dac_word_out;
  wire [2:0] output_span_sel;
  wire [1:0] preset_scale;
  // bookkeeping
  int errors = 0, samples_checked = 0;
  logic [23:0] exp_q[$];
  ctrl_fields_t f;
  always #2 clk = ~clk;
  dac_control_register u_dut (.clk, .reset_n, .ce(1'b1), .sclk, .sync_n, .sdi, .serial_out, .clear_n, .short_det,
    .undervolt_det, .overtemp_det, .dac_load, .dac_word_in, .dac_word_out, .out_clamp_en, .out_buf_pwr, .alert_n,
    .digital_supply_off, .internal_vref_on, .range_extend_en, .output_span_sel, .preset_active, .preset_scale);
  dac_host_model u_host (.sclk, .sync_n, .sdi, .serial_out, .rx_valid, .rx_word);
  // compare one value
  task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // every answer frame is matched with the oldest note
  always @(posedge rx_valid) chk("readback", exp_q.pop_front(), rx_word);
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // frame, then time for the command to act
  task automatic send(input logic [23:0] w);
    u_host.xfer(w, 1'b0);
    wclk(10);
  endtask
  // readback request with junk data, then a no-op frame carries the answer
  task automatic rb(input logic [12:0] low);
    exp_q.push_back({8'h0C, 3'h0, low});
    send({3'($urandom), 1'b0, CMD_READ_CTRL, 16'($urandom)});
    u_host.xfer(24'h000000, 1'b1);
  endtask
  // control write with junk in the ignored bits
  task automatic wr(input ctrl_fields_t v);
    send({3'($urandom), 1'b0, CMD_WRITE_CTRL, 5'($urandom), v});
  endtask
  function automatic logic [1:0] scl(input logic [1:0] c);
    return c[1] ? 2'h2 : c;
  endfunction
  // verdict
  task automatic test_done();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    reset_n <= 1'b0; // a true falling edge, so the link-clock flops reset too
    void'($urandom(77));
    wclk(12);
    reset_n <= 1'b1;
    wclk(4);
    chk("clamp", 1, out_clamp_en);
    chk("buffer", 0, out_buf_pwr);
    chk("alert", 0, alert_n);
    rb(13'h0000);
    for (int i = 0; i < 8; i++) begin
      send({4'h0, CMD_FULL_RESET, 16'h0000});
      chk("clamp again", 1, out_clamp_en);
      chk("alert again", 0, alert_n);
      chk("span reset", 0, output_span_sel);
      f = ctrl_fields_t'($urandom);
      f.output_span_sel = 3'(i);
      f.clear_code_sel = 2'(i);
      f.powerup_code_sel = 2'(i >> 1);
      f.thermal_supply_cut = i[0];
      wr(f);
      chk("clamp off", 0, out_clamp_en);
      chk("buffer on", 1, out_buf_pwr);
      chk("alert high", 1, alert_n);
      chk("span", f.output_span_sel, output_span_sel);
      chk("vref", f.internal_vref_on, internal_vref_on);
      chk("overrange", f.range_extend_en, range_extend_en);
      chk("powerup", {1'b1, scl(f.powerup_code_sel)}, {preset_active, preset_scale});
      rb({2'h0, f});
      @(posedge clk);
      dac_word_in <= 16'($urandom);
      dac_load <= 1'b1;
      @(posedge clk);
      dac_load <= 1'b0;
      wclk(3);
      chk("coded word", dac_word_in ^ {f.signed_coding_sel, 15'h0}, dac_word_out);
      chk("load ends preset", 0, preset_active);
      clear_n <= 1'b0;
      wclk(8);
      chk("clear", {1'b1, scl(f.clear_code_sel)}, {preset_active, preset_scale});
      clear_n <= 1'b1;
      overtemp_det <= 1'b1;
      wclk(8);
      chk("supply cut", f.thermal_supply_cut, digital_supply_off);
      chk("alert hot", 0, alert_n);
      chk("clear held", 1, preset_active);
      overtemp_det <= 1'b0;
      wclk(8);
      // a load frame ends the clear hold
      send({4'h0, (i[0] ? CMD_WRITE_UPDATE : CMD_UPDATE_DAC), 16'($urandom)});
      chk("clear ends", 0, preset_active);
    end
    short_det <= 1'b1;
    undervolt_det <= 1'b1;
    wclk(8);
    short_det <= 1'b0;
    undervolt_det <= 1'b0;
    wclk(8);
    rb({2'h3, f});
    send({4'h1, CMD_WRITE_CTRL, 16'h0000}); // fixed-zero bit set, so ignored
    rb({2'h3, f});
    wr(f);
    rb({2'h0, f});
    wclk(10);
    test_done();
  end
  // watchdog
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
